/* File: hw/msdeb_pkg.sv */
// Constants, commands, states and carriers for the memory space decoder and external bus.
package msdeb_pkg;

  localparam logic [7:0] MSDEB_SP_RESET = 8'h07;
  localparam logic [7:0] MSDEB_SFR_SP_ADDR = 8'h81;
  localparam logic [7:0] MSDEB_IDATA_SPLIT = 8'h7f;
  localparam logic [7:0] MSDEB_BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] MSDEB_PORT_LATCH_FILL = 8'hff;
  localparam logic [15:0] MSDEB_AUX_TOP = 16'h03ff;
  localparam int MSDEB_IDATA_DEPTH = 256;
  localparam int MSDEB_AUX_DEPTH = 1024;
  localparam logic [16:0] MSDEB_CODE_SPACE = 17'h10000;
  localparam logic [16:0] MSDEB_APP_BANK_BYTES = 17'h08000;
  localparam logic [16:0] MSDEB_LOADER_BANK_BYTES = 17'h01000;
  localparam logic [2:0] MSDEB_STROBE_CYCLES = 3'h3;
  localparam logic [1:0] MSDEB_STRAP_DELAY = 2'h2;

  typedef enum logic [3:0] {
    MSDEB_CMD_FETCH = 4'h0,
    MSDEB_CMD_CODE_MOVE = 4'h1,
    MSDEB_CMD_DIR_RD = 4'h2,
    MSDEB_CMD_DIR_WR = 4'h3,
    MSDEB_CMD_IND_RD = 4'h4,
    MSDEB_CMD_IND_WR = 4'h5,
    MSDEB_CMD_REG_RD = 4'h6,
    MSDEB_CMD_REG_WR = 4'h7,
    MSDEB_CMD_BIT_RD = 4'h8,
    MSDEB_CMD_BIT_WR = 4'h9,
    MSDEB_CMD_PUSH = 4'ha,
    MSDEB_CMD_POP = 4'hb,
    MSDEB_CMD_XRD16 = 4'hc,
    MSDEB_CMD_XWR16 = 4'hd,
    MSDEB_CMD_XRD8 = 4'he,
    MSDEB_CMD_XWR8 = 4'hf
  } msdeb_cmd_type;

  typedef enum logic [2:0] {
    MSDEB_ST_IDLE = 3'h0,
    MSDEB_ST_ADDR = 3'h1,
    MSDEB_ST_LATCH = 3'h3,
    MSDEB_ST_STROBE = 3'h2,
    MSDEB_ST_HOLD = 3'h6,
    MSDEB_ST_WAIT = 3'h4
  } msdeb_state_type;

  typedef struct packed {
    msdeb_cmd_type cmd;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } msdeb_req_type;

  typedef struct packed {
    logic ale;
    logic program_fetch_strobe_n;
    logic rd_n;
    logic wr_n;
  } msdeb_strobe_type;

endpackage : msdeb_pkg

/* File: hw/msdeb_top.sv */
// Memory space decoder, internal data RAM, auxiliary RAM and multiplexed external bus.
// Summary of operation
// - Pin high at power-on: fetch externally once PC passes the selected bank size.
// - Pin low at power-on: all 64k code bytes fetched externally.
// - External execution owns low port for address/data, high port for address.
// - External code fetches pulse the program fetch strobe.
// - Access pin captured once after each reset; later changes ignored until the next reset.
// - Lock bit 0 blocks code moves of internal banks from external code.
// - Direct above 7FH reaches SFRs; indirect above 7FH reaches upper RAM.
// - SFR addresses ending 0H or 8H are byte and bit addressable.
// - Lowest 32 bytes are four register banks picked by two bank bits.
// - Bytes 20H-2FH hold bit addresses 00H-7FH ascending.
// - Stack pointer resets 07H; push pre-increments, pop reads then decrements.
// - 1024-byte auxiliary RAM at 000H-3FFH, reached by external moves only.
// - External moves below 400H go outside only when aux RAM disabled.
// - 16-bit data access: low port, high port, read and write strobes.
// - 8-bit data access drives only low address, high port stays free unless code is executing externally.
// - Low address valid on low port at falling edge of latch strobe.
// - Write data on low port before write strobe and after its release.
// - Read data sampled on low port just before read strobe release.
// - Every external access loads 0FFH into the low port latch.
`timescale 1ns/1ps
module msdeb_top #(
  parameter logic [16:0] APP_BANK_BYTES = msdeb_pkg::MSDEB_APP_BANK_BYTES,
  parameter logic [16:0] LOADER_BANK_BYTES = msdeb_pkg::MSDEB_LOADER_BANK_BYTES,
  parameter logic [2:0] STROBE_CYCLES = msdeb_pkg::MSDEB_STROBE_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic external_access_pin_n_i,
  input wire logic code_read_lock_i,
  input wire logic aux_ram_enable_i,
  input wire logic loader_bank_sel_i,
  input wire logic bank_select_high_i,
  input wire logic bank_select_low_i,
  input wire logic [1:0] aux_page_i,
  input wire logic req_valid_i,
  input wire msdeb_pkg::msdeb_req_type req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic blocked_o,
  output logic exec_external_o,
  output logic [7:0] stack_pointer_o,
  output logic sfr_req_o,
  output logic sfr_we_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  output logic code_req_o,
  output logic [15:0] code_addr_o,
  input wire logic [7:0] code_rdata_i,
  output logic [7:0] low_port_out_o,
  output logic low_port_oe_o,
  input wire logic [7:0] low_port_in_i,
  output logic [7:0] high_port_out_o,
  output logic high_port_oe_o,
  output logic high_port_owned_o,
  output msdeb_pkg::msdeb_strobe_type strobes_o,
  input wire logic latch_wr_i,
  input wire logic [7:0] latch_wdata_i,
  output logic [7:0] low_port_latch_o
);
  import msdeb_pkg::*;

  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] i,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[i] = v;
    return r;
  endfunction : put_bit

  logic [7:0] idata_mem [0:MSDEB_IDATA_DEPTH-1];
  logic [7:0] aux_mem [0:MSDEB_AUX_DEPTH-1];

  logic ea_meta_ff, ea_sync_ff;
  logic [7:0] p0_meta_ff, p0_sync_ff;
  logic [1:0] strap_cnt_ff, nxt_strap_cnt;
  logic strap_done_ff, nxt_strap_done, ea_int_ff, nxt_ea_int;
  msdeb_state_type state_ff, nxt_state;
  msdeb_cmd_type cmd_ff, nxt_cmd;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic bit_ff, nxt_bit, use16_ff, nxt_use16;
  logic [2:0] cnt_ff, nxt_cnt;
  logic ready_ff, nxt_ready, done_ff, nxt_done, blocked_ff, nxt_blocked;
  logic [7:0] rdata_ff, nxt_rdata, sp_ff, nxt_sp;
  logic exec_ext_ff, nxt_exec_ext;
  logic sfr_req_ff, nxt_sfr_req, sfr_we_ff, nxt_sfr_we;
  logic [7:0] sfr_addr_ff, nxt_sfr_addr, sfr_wdata_ff, nxt_sfr_wdata;
  logic code_req_ff, nxt_code_req;
  logic [15:0] code_addr_ff, nxt_code_addr;
  logic [7:0] p0_out_ff, nxt_p0_out, p2_out_ff, nxt_p2_out, latch_ff, nxt_latch;
  logic p0_oe_ff, nxt_p0_oe, p2_oe_ff, nxt_p2_oe, owned_ff, nxt_owned;
  msdeb_strobe_type strobe_ff, nxt_strobe;
  logic ram_we, aux_we;
  logic [7:0] ram_wa, ram_wd, aux_wd;
  logic [9:0] aux_wa;
  logic [16:0] bank_size;
  logic [7:0] ram_byte, bit_byte;
  logic [15:0] xaddr;
  logic ext_code, is_write;

  always_comb
  begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_strap_done = strap_done_ff;
    nxt_ea_int = ea_int_ff;
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_bit = bit_ff;
    nxt_use16 = use16_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_blocked = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_sp = sp_ff;
    nxt_exec_ext = exec_ext_ff;
    nxt_sfr_req = 1'b0;
    nxt_sfr_we = 1'b0;
    nxt_sfr_addr = sfr_addr_ff;
    nxt_sfr_wdata = sfr_wdata_ff;
    nxt_code_req = 1'b0;
    nxt_code_addr = code_addr_ff;
    nxt_p0_out = p0_out_ff;
    nxt_p0_oe = p0_oe_ff;
    nxt_p2_out = p2_out_ff;
    nxt_latch = latch_wr_i ? latch_wdata_i : latch_ff;
    nxt_strobe = strobe_ff;
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    aux_we = 1'b0;
    aux_wa = 10'h000;
    aux_wd = 8'h00;
    bank_size = loader_bank_sel_i ? LOADER_BANK_BYTES : APP_BANK_BYTES;
    ext_code = !ea_int_ff || ({1'b0, req_i.addr} >= bank_size);
    ram_byte = 8'h00;
    bit_byte = MSDEB_BIT_AREA_BASE + {4'h0, req_i.addr[6:3]};
    xaddr = req_i.cmd[1] ? {6'h00, aux_page_i, req_i.addr[7:0]} : req_i.addr;
    is_write = (cmd_ff == MSDEB_CMD_XWR16) || (cmd_ff == MSDEB_CMD_XWR8);
    // Strap is caught only after the synchroniser has settled
    if (!strap_done_ff)
    begin
      nxt_strap_cnt = 2'(strap_cnt_ff + 2'h1);
      if (strap_cnt_ff == MSDEB_STRAP_DELAY)
      begin
        nxt_strap_done = 1'b1;
        nxt_ea_int = ea_sync_ff;
      end
    end
    case (state_ff)
      MSDEB_ST_IDLE:
      begin
        nxt_p0_oe = 1'b0;
        if (req_valid_i && ready_ff)
        begin
          nxt_cmd = req_i.cmd;
          nxt_wdata = req_i.wdata;
          nxt_bit = req_i.bit_val;
          nxt_addr = req_i.addr;
          nxt_use16 = 1'b1;
          nxt_done = 1'b1;
          case (req_i.cmd)
            MSDEB_CMD_FETCH, MSDEB_CMD_CODE_MOVE:
            begin
              if (req_i.cmd == MSDEB_CMD_FETCH)
                nxt_exec_ext = ext_code;
              if (ext_code)
              begin
                nxt_done = 1'b0;
                nxt_state = MSDEB_ST_ADDR;
              end
              else if (req_i.cmd == MSDEB_CMD_CODE_MOVE && exec_ext_ff && !code_read_lock_i)
              begin
                nxt_blocked = 1'b1;
                nxt_rdata = 8'h00;
              end
              else
              begin
                nxt_done = 1'b0;
                nxt_code_req = 1'b1;
                nxt_code_addr = req_i.addr;
                nxt_state = MSDEB_ST_WAIT;
              end
            end
            MSDEB_CMD_DIR_RD, MSDEB_CMD_DIR_WR:
            begin
              if (req_i.addr[7:0] > MSDEB_IDATA_SPLIT)
              begin
                if (req_i.addr[7:0] == MSDEB_SFR_SP_ADDR)
                begin
                  if (req_i.cmd == MSDEB_CMD_DIR_WR)
                    nxt_sp = req_i.wdata;
                  else
                    nxt_rdata = sp_ff;
                end
                else
                begin
                  nxt_sfr_req = 1'b1;
                  nxt_sfr_we = (req_i.cmd == MSDEB_CMD_DIR_WR);
                  nxt_sfr_addr = req_i.addr[7:0];
                  nxt_sfr_wdata = req_i.wdata;
                  if (req_i.cmd == MSDEB_CMD_DIR_RD)
                  begin
                    nxt_done = 1'b0;
                    nxt_state = MSDEB_ST_WAIT;
                  end
                end
              end
              else
                ram_byte = req_i.addr[7:0];
            end
            MSDEB_CMD_IND_RD, MSDEB_CMD_IND_WR:
              ram_byte = req_i.addr[7:0];
            MSDEB_CMD_REG_RD, MSDEB_CMD_REG_WR:
              ram_byte = {3'h0, bank_select_high_i, bank_select_low_i, req_i.addr[2:0]};
            MSDEB_CMD_BIT_RD, MSDEB_CMD_BIT_WR:
            begin
              if (req_i.addr[7])
              begin
                // Bit writes to SFRs are read-modify-write over two cycles
                nxt_sfr_req = 1'b1;
                nxt_sfr_addr = {req_i.addr[7:3], 3'h0};
                nxt_done = 1'b0;
                nxt_state = MSDEB_ST_WAIT;
              end
              else
              begin
                nxt_rdata = {7'h00, idata_mem[bit_byte][req_i.addr[2:0]]};
                if (req_i.cmd == MSDEB_CMD_BIT_WR)
                begin
                  ram_we = 1'b1;
                  ram_wa = bit_byte;
                  ram_wd = put_bit(idata_mem[bit_byte], req_i.addr[2:0], req_i.bit_val);
                end
              end
            end
            MSDEB_CMD_PUSH:
            begin
              nxt_sp = sp_ff + 8'h01;
              ram_we = 1'b1;
              ram_wa = sp_ff + 8'h01;
              ram_wd = req_i.wdata;
            end
            MSDEB_CMD_POP:
            begin
              nxt_rdata = idata_mem[sp_ff];
              nxt_sp = sp_ff - 8'h01;
            end
            default:
            begin
              nxt_use16 = !req_i.cmd[1];
              nxt_addr = xaddr;
              if (aux_ram_enable_i && xaddr <= MSDEB_AUX_TOP)
              begin
                nxt_rdata = aux_mem[xaddr[9:0]];
                aux_we = req_i.cmd[0];
                aux_wa = xaddr[9:0];
                aux_wd = req_i.wdata;
              end
              else
              begin
                nxt_done = 1'b0;
                nxt_state = MSDEB_ST_ADDR;
              end
            end
          endcase
          if (ram_byte != 8'h00 || req_i.cmd inside {MSDEB_CMD_IND_RD, MSDEB_CMD_IND_WR,
              MSDEB_CMD_REG_RD, MSDEB_CMD_REG_WR, MSDEB_CMD_DIR_RD, MSDEB_CMD_DIR_WR})
          begin
            if (req_i.cmd inside {MSDEB_CMD_IND_RD, MSDEB_CMD_IND_WR, MSDEB_CMD_REG_RD,
                MSDEB_CMD_REG_WR} || req_i.addr[7:0] <= MSDEB_IDATA_SPLIT)
            begin
              nxt_rdata = idata_mem[ram_byte];
              ram_we = req_i.cmd[0];
              ram_wa = ram_byte;
              ram_wd = req_i.wdata;
            end
          end
          if (nxt_state == MSDEB_ST_ADDR)
          begin
            nxt_p0_out = nxt_addr[7:0];
            nxt_p0_oe = 1'b1;
            nxt_p2_out = nxt_addr[15:8];
            nxt_strobe.ale = 1'b1;
            nxt_latch = MSDEB_PORT_LATCH_FILL;
          end
        end
      end
      MSDEB_ST_ADDR:
      begin
        nxt_strobe.ale = 1'b0;
        nxt_state = MSDEB_ST_LATCH;
      end
      MSDEB_ST_LATCH:
      begin
        nxt_state = MSDEB_ST_STROBE;
        nxt_cnt = STROBE_CYCLES;
        if (is_write)
          nxt_p0_out = wdata_ff;
        else
          nxt_p0_oe = 1'b0;
        if (cmd_ff inside {MSDEB_CMD_FETCH, MSDEB_CMD_CODE_MOVE})
          nxt_strobe.program_fetch_strobe_n = 1'b0;
        else if (!is_write)
          nxt_strobe.rd_n = 1'b0;
      end
      MSDEB_ST_STROBE:
      begin
        // Write strobe lags the data by one cycle for setup
        if (is_write)
          nxt_strobe.wr_n = 1'b0;
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff <= 3'h1)
        begin
          nxt_state = MSDEB_ST_HOLD;
          nxt_strobe = '{ale: 1'b0, program_fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
          if (!is_write)
            nxt_rdata = p0_sync_ff;
        end
      end
      MSDEB_ST_HOLD:
      begin
        nxt_p0_oe = 1'b0;
        nxt_done = 1'b1;
        nxt_state = MSDEB_ST_IDLE;
      end
      MSDEB_ST_WAIT:
      begin
        nxt_done = 1'b1;
        nxt_state = MSDEB_ST_IDLE;
        if (cmd_ff inside {MSDEB_CMD_FETCH, MSDEB_CMD_CODE_MOVE})
          nxt_rdata = code_rdata_i;
        else if (cmd_ff == MSDEB_CMD_DIR_RD)
          nxt_rdata = sfr_rdata_i;
        else
        begin
          nxt_rdata = {7'h00, sfr_rdata_i[addr_ff[2:0]]};
          if (cmd_ff == MSDEB_CMD_BIT_WR)
          begin
            nxt_sfr_req = 1'b1;
            nxt_sfr_we = 1'b1;
            nxt_sfr_wdata = put_bit(sfr_rdata_i, addr_ff[2:0], bit_ff);
          end
        end
      end
      default:
        nxt_state = MSDEB_ST_IDLE;
    endcase
    nxt_ready = nxt_strap_done && (nxt_state == MSDEB_ST_IDLE);
    // High port stays on the bus between external fetches
    nxt_owned = nxt_exec_ext || (nxt_state != MSDEB_ST_IDLE && nxt_use16);
    nxt_p2_oe = nxt_owned;
  end

  always_ff @(posedge clk_i)
  begin
    ea_meta_ff <= external_access_pin_n_i;
    ea_sync_ff <= ea_meta_ff;
    p0_meta_ff <= low_port_in_i;
    p0_sync_ff <= p0_meta_ff;
    if (ram_we)
      idata_mem[ram_wa] <= ram_wd;
    if (aux_we)
      aux_mem[aux_wa] <= aux_wd;
    if (srst_i)
    begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      ea_int_ff <= 1'b0;
      state_ff <= MSDEB_ST_IDLE;
      cmd_ff <= MSDEB_CMD_FETCH;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      bit_ff <= 1'b0;
      use16_ff <= 1'b0;
      cnt_ff <= 3'h0;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      blocked_ff <= 1'b0;
      rdata_ff <= 8'h00;
      sp_ff <= MSDEB_SP_RESET;
      exec_ext_ff <= 1'b0;
      sfr_req_ff <= 1'b0;
      sfr_we_ff <= 1'b0;
      sfr_addr_ff <= 8'h00;
      sfr_wdata_ff <= 8'h00;
      code_req_ff <= 1'b0;
      code_addr_ff <= 16'h0000;
      p0_out_ff <= 8'h00;
      p0_oe_ff <= 1'b0;
      p2_out_ff <= 8'h00;
      p2_oe_ff <= 1'b0;
      owned_ff <= 1'b0;
      latch_ff <= MSDEB_PORT_LATCH_FILL;
      strobe_ff <= '{ale: 1'b0, program_fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
    end
    else
    begin
      strap_cnt_ff <= nxt_strap_cnt;
      strap_done_ff <= nxt_strap_done;
      ea_int_ff <= nxt_ea_int;
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      bit_ff <= nxt_bit;
      use16_ff <= nxt_use16;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
      blocked_ff <= nxt_blocked;
      rdata_ff <= nxt_rdata;
      sp_ff <= nxt_sp;
      exec_ext_ff <= nxt_exec_ext;
      sfr_req_ff <= nxt_sfr_req;
      sfr_we_ff <= nxt_sfr_we;
      sfr_addr_ff <= nxt_sfr_addr;
      sfr_wdata_ff <= nxt_sfr_wdata;
      code_req_ff <= nxt_code_req;
      code_addr_ff <= nxt_code_addr;
      p0_out_ff <= nxt_p0_out;
      p0_oe_ff <= nxt_p0_oe;
      p2_out_ff <= nxt_p2_out;
      p2_oe_ff <= nxt_p2_oe;
      owned_ff <= nxt_owned;
      latch_ff <= nxt_latch;
      strobe_ff <= nxt_strobe;
    end
  end

  assign req_ready_o = ready_ff;
  assign done_o = done_ff;
  assign rdata_o = rdata_ff;
  assign blocked_o = blocked_ff;
  assign exec_external_o = exec_ext_ff;
  assign stack_pointer_o = sp_ff;
  assign sfr_req_o = sfr_req_ff;
  assign sfr_we_o = sfr_we_ff;
  assign sfr_addr_o = sfr_addr_ff;
  assign sfr_wdata_o = sfr_wdata_ff;
  assign code_req_o = code_req_ff;
  assign code_addr_o = code_addr_ff;
  assign low_port_out_o = p0_out_ff;
  assign low_port_oe_o = p0_oe_ff;
  assign high_port_out_o = p2_out_ff;
  assign high_port_oe_o = p2_oe_ff;
  assign high_port_owned_o = owned_ff;
  assign strobes_o = strobe_ff;
  assign low_port_latch_o = latch_ff;

endmodule : msdeb_top

/* File: dv/msdeb_sva.sv */
// Concurrent checks on the external bus, stack pointer and refusals of the decoder.
`timescale 1ns/1ps
module msdeb_sva
  import msdeb_pkg::*;
#(
  parameter logic [2:0] STROBE_CYCLES = MSDEB_STROBE_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic done_o,
  input wire logic [7:0] rdata_o,
  input wire logic blocked_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic [7:0] low_port_out_o,
  input wire logic low_port_oe_o,
  input wire logic high_port_oe_o,
  input wire logic high_port_owned_o,
  input wire msdeb_pkg::msdeb_strobe_type strobes_o,
  input wire logic [7:0] low_port_latch_o
);
  logic [3:0] low_cnt_ff;
  logic [3:0] nxt_low_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Strobe length, checked at release
  always_comb
  begin
    nxt_low_cnt = 4'h0;
    if (!strobes_o.rd_n || !strobes_o.program_fetch_strobe_n)
      nxt_low_cnt = low_cnt_ff + 4'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      low_cnt_ff <= 4'h0;
    else
      low_cnt_ff <= nxt_low_cnt;
  end
  chk_ale_addr_hold: assert property ($fell(strobes_o.ale) |-> low_port_oe_o && $stable(low_port_out_o))
    else $error("low address moved at latch strobe fall");
  chk_wr_data_setup: assert property ($fell(strobes_o.wr_n) |-> low_port_oe_o && $stable(low_port_out_o))
    else $error("write data not ready before write strobe");
  chk_wr_data_hold: assert property ($rose(strobes_o.wr_n) |-> low_port_oe_o && $stable(low_port_out_o))
    else $error("write data dropped at write strobe release");
  chk_rd_port_free: assert property (!strobes_o.rd_n |-> !low_port_oe_o)
    else $error("low port driven during read");
  chk_strobe_len: assert property (($rose(strobes_o.rd_n) || $rose(strobes_o.program_fetch_strobe_n)) |-> low_cnt_ff == {1'b0, STROBE_CYCLES})
    else $error("read strobe length wrong");
  chk_latch_fill: assert property ($rose(strobes_o.ale) |-> low_port_latch_o == MSDEB_PORT_LATCH_FILL)
    else $error("low port latch not filled on access");
  chk_sp_reset: assert property ($fell(srst_i) |-> stack_pointer_o == MSDEB_SP_RESET)
    else $error("stack pointer reset value wrong");
  chk_fetch_owns: assert property (!strobes_o.program_fetch_strobe_n |-> high_port_oe_o && high_port_owned_o)
    else $error("high port not owned during fetch");
  chk_one_strobe: assert property ($onehot0({~strobes_o.rd_n, ~strobes_o.wr_n, ~strobes_o.program_fetch_strobe_n, strobes_o.ale}))
    else $error("two bus strobes active together");
  chk_block_zero: assert property (blocked_o |-> done_o && rdata_o == 8'h00)
    else $error("refused code move returned data");
  cov_ext_write: cover property ($rose(strobes_o.wr_n));
  cov_ext_fetch: cover property ($rose(strobes_o.program_fetch_strobe_n));
  cov_blocked: cover property (blocked_o);
endmodule : msdeb_sva
bind msdeb_top msdeb_sva #(.STROBE_CYCLES(STROBE_CYCLES)) chk_u (.clk_i, .srst_i, .done_o,
  .rdata_o, .blocked_o, .stack_pointer_o, .low_port_out_o, .low_port_oe_o, .high_port_oe_o,
  .high_port_owned_o, .strobes_o, .low_port_latch_o);

/* File: dv/msdeb_ext_mem.sv */
// Behavioural external program and data memory behind an address latch.
`timescale 1ns/1ps
module msdeb_ext_mem #(
  parameter int DLY_NS = 5
) (
  input wire logic [7:0] low_port_out_i,
  input wire logic low_port_oe_i,
  output logic [7:0] low_port_in_o,
  input wire logic [7:0] high_port_out_i,
  input wire logic high_port_oe_i,
  input wire msdeb_pkg::msdeb_strobe_type strobes_i
);
  logic [7:0] mem [int];
  logic [15:0] addr = 16'h0000;
  initial low_port_in_o = 8'h5a;
  function automatic logic [7:0] peek(input logic [15:0] x);
    return mem.exists(x) ? mem[x] : x[7:0] ^ x[15:8];
  endfunction : peek
  // Undriven high port reads as page zero
  always @(negedge strobes_i.ale)
    addr = {high_port_oe_i ? high_port_out_i : 8'h00, low_port_out_i};
  always @(posedge strobes_i.wr_n)
    if (low_port_oe_i === 1'b1)
      mem[addr] = low_port_out_i;
  // Data held until strobe release; afterwards the bus shows no stale byte
  always @(strobes_i.rd_n or strobes_i.program_fetch_strobe_n)
    if (!strobes_i.rd_n || !strobes_i.program_fetch_strobe_n)
      low_port_in_o <= #(DLY_NS) peek(addr);
    else
      low_port_in_o <= #(DLY_NS) ~low_port_in_o;
endmodule : msdeb_ext_mem

/* File: dv/msdeb_top_tb.sv */
// Self-checking bench for the memory space decoder and external bus.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module msdeb_top_tb;
  import msdeb_pkg::*;
  int n_fail = 0;
  int compares = 0;
  int seed, i, ale_n = 0, hp_n = 0, sp = 7;
  logic clk_i = 1'b0, srst_i = 1'b1, pin_n = 1'b1, lock = 1'b0, aux_en = 1'b0, ldr = 1'b0;
  logic bsh = 1'b0, bsl = 1'b0, req_valid_i = 1'b0, latch_wr_i = 1'b0, blk_v, bv;
  logic [1:0] page = 2'h0;
  msdeb_req_type req_i = '0;
  logic [7:0] sfr_rdata_i = 8'h00, code_rdata_i = 8'h00, latch_wdata_i = 8'h00;
  logic [7:0] ext [int];
  logic [15:0] sfr_wa = 16'h0000;
  logic [7:0] rd_v, d, e, a, mem_drv, low_port_in_i;
  logic [6:0] b;
  logic req_ready_o, done_o, blocked_o, exec_external_o, sfr_req_o, sfr_we_o, code_req_o;
  logic low_port_oe_o, high_port_oe_o, high_port_owned_o;
  logic [7:0] rdata_o, stack_pointer_o, sfr_addr_o, sfr_wdata_o, low_port_out_o;
  logic [7:0] high_port_out_o, low_port_latch_o;
  logic [15:0] code_addr_o;
  msdeb_strobe_type strobes_o;
  assign low_port_in_i = low_port_oe_o ? low_port_out_o : mem_drv;
  msdeb_top #(.STROBE_CYCLES(3'h4)) dut_u (.clk_i, .srst_i,
    .external_access_pin_n_i(pin_n), .code_read_lock_i(lock), .aux_ram_enable_i(aux_en),
    .loader_bank_sel_i(ldr), .bank_select_high_i(bsh), .bank_select_low_i(bsl),
    .aux_page_i(page), .req_valid_i, .req_i, .req_ready_o, .done_o, .rdata_o, .blocked_o,
    .exec_external_o, .stack_pointer_o, .sfr_req_o, .sfr_we_o, .sfr_addr_o, .sfr_wdata_o,
    .sfr_rdata_i, .code_req_o, .code_addr_o, .code_rdata_i, .low_port_out_o, .low_port_oe_o,
    .low_port_in_i, .high_port_out_o, .high_port_oe_o, .high_port_owned_o, .strobes_o,
    .latch_wr_i, .latch_wdata_i, .low_port_latch_o);
  msdeb_ext_mem mem_u (.low_port_out_i(low_port_out_o), .low_port_oe_i(low_port_oe_o),
    .low_port_in_o(mem_drv), .high_port_out_i(high_port_out_o),
    .high_port_oe_i(high_port_oe_o), .strobes_i(strobes_o));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (sfr_req_o === 1'b1 && sfr_we_o === 1'b1)
      sfr_wa <= {sfr_addr_o, sfr_wdata_o};
    if (strobes_o.ale === 1'b1)
      ale_n <= ale_n + 1;
    if ((strobes_o.rd_n === 1'b0 || strobes_o.wr_n === 1'b0) && high_port_oe_o === 1'b1)
      hp_n <= hp_n + 1;
  end
  function automatic logic [7:0] ext_rd(input logic [15:0] x);
    return ext.exists(x) ? ext[x] : x[7:0] ^ x[15:8];
  endfunction : ext_rd
  task automatic op(input msdeb_cmd_type c, input logic [15:0] ad, input logic [7:0] wd,
                    input logic bt);
    int n = 0;
    @(negedge clk_i);
    req_i = '{cmd: c, addr: ad, wdata: wd, bit_val: bt};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && n < 60)
    begin
      n++;
      @(negedge clk_i);
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 60)
    begin
      n++;
      @(negedge clk_i);
    end
    if (n >= 60)
      n_fail++;
    rd_v = rdata_o;
    blk_v = blocked_o;
  endtask : op
  task automatic rchk(input msdeb_cmd_type c, input logic [15:0] ad, input logic [7:0] ex);
    op(c, ad, 8'h00, 1'b0);
    `CHK(rd_v, ex)
  endtask : rchk
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    #(20 * 20000);
    n_fail++;
    summarize();
  end
  initial
  begin
    seed = 32'hbb11;
    sfr_rdata_i = 8'($random(seed));
    code_rdata_i = 8'($random(seed));
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    @(negedge clk_i);
    `CHK(stack_pointer_o, MSDEB_SP_RESET)
    `CHK(low_port_latch_o, 8'hff)
    for (i = 0; i < 8; i++)
    begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      op(MSDEB_CMD_IND_WR, {8'h00, a}, d, 1'b0);
      rchk(MSDEB_CMD_IND_RD, {8'h00, a}, d);
      rchk(MSDEB_CMD_DIR_RD, {9'h001, a[6:4], 4'h0}, sfr_rdata_i);
      op(MSDEB_CMD_BIT_RD, {9'h001, a[6:0]}, 8'h00, 1'b0);
      `CHK({rd_v[0], sfr_addr_o}, {sfr_rdata_i[a[2:0]], 1'b1, a[6:3], 3'h0})
    end
    op(MSDEB_CMD_DIR_WR, 16'h0090, d, 1'b0);
    @(negedge clk_i);
    `CHK(sfr_wa, {8'h90, d})
    $display("end of test data spaces");
    for (i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      {bsh, bsl} = 2'(i);
      op(MSDEB_CMD_REG_WR, 16'(i + 3), d, 1'b0);
      rchk(MSDEB_CMD_DIR_RD, 16'(i * 9 + 3), d);
      b = (i == 0) ? 7'h7f : 7'($random(seed));
      bv = ~d[b[2:0]];
      op(MSDEB_CMD_DIR_WR, {8'h00, 4'h2, b[6:3]}, d, 1'b0);
      op(MSDEB_CMD_BIT_WR, {9'h000, b}, 8'h00, bv);
      d[b[2:0]] = bv;
      rchk(MSDEB_CMD_DIR_RD, {8'h00, 4'h2, b[6:3]}, d);
    end
    d = 8'($random(seed));
    e = ~d;
    op(MSDEB_CMD_PUSH, 16'h0000, d, 1'b0);
    op(MSDEB_CMD_PUSH, 16'h0000, e, 1'b0);
    sp = sp + 2;
    `CHK(stack_pointer_o, 8'(sp))
    rchk(MSDEB_CMD_DIR_RD, 16'(sp), e);
    rchk(MSDEB_CMD_POP, 16'h0000, e);
    rchk(MSDEB_CMD_POP, 16'h0000, d);
    `CHK(stack_pointer_o, 8'(sp - 2))
    $display("end of test banks bits stack");
    aux_en = 1'b1;
    page = 2'h3;
    i = ale_n;
    op(MSDEB_CMD_XWR16, 16'h03ff, d, 1'b0);
    rchk(MSDEB_CMD_XRD8, 16'h00ff, d);
    rchk(MSDEB_CMD_XRD16, 16'h03ff, d);
    `CHK(ale_n, i)
    latch_wdata_i = e;
    latch_wr_i = 1'b1;
    @(negedge clk_i);
    latch_wr_i = 1'b0;
    @(negedge clk_i);
    `CHK(low_port_latch_o, e)
    op(MSDEB_CMD_XWR16, 16'h8001, e, 1'b0);
    ext[16'h8001] = e;
    `CHK(low_port_latch_o, 8'hff)
    rchk(MSDEB_CMD_XRD16, 16'h8001, e);
    `CHK(ale_n, i + 2)
    aux_en = 1'b0;
    op(MSDEB_CMD_XWR16, 16'h03ff, e, 1'b0);
    ext[16'h03ff] = e;
    rchk(MSDEB_CMD_XRD16, 16'h03ff, e);
    rchk(MSDEB_CMD_XRD16, 16'h12c4, ext_rd(16'h12c4));
    aux_en = 1'b1;
    rchk(MSDEB_CMD_XRD16, 16'h03ff, d);
    aux_en = 1'b0;
    i = hp_n;
    op(MSDEB_CMD_XWR8, 16'h0042, d, 1'b0);
    ext[16'h0042] = d;
    rchk(MSDEB_CMD_XRD8, 16'h0042, d);
    `CHK(hp_n, i)
    $display("end of test external data");
    rchk(MSDEB_CMD_FETCH, 16'h0100, code_rdata_i);
    `CHK(exec_external_o, 1'b0)
    rchk(MSDEB_CMD_FETCH, 16'h8000, ext_rd(16'h8000));
    `CHK(exec_external_o, 1'b1)
    ldr = 1'b1;
    rchk(MSDEB_CMD_FETCH, 16'h1000, ext_rd(16'h1000));
    op(MSDEB_CMD_CODE_MOVE, 16'h0010, 8'h00, 1'b0);
    `CHK({blk_v, rd_v}, 9'h100)
    lock = 1'b1;
    op(MSDEB_CMD_CODE_MOVE, 16'h0010, 8'h00, 1'b0);
    `CHK({blk_v, rd_v}, {1'b0, code_rdata_i})
    pin_n = 1'b0;
    ldr = 1'b0;
    rchk(MSDEB_CMD_FETCH, 16'h0100, code_rdata_i);
    `CHK(exec_external_o, 1'b0)
    srst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    rchk(MSDEB_CMD_FETCH, 16'h0100, ext_rd(16'h0100));
    `CHK(exec_external_o, 1'b1)
    $display("end of test code space");
    summarize();
  end
endmodule : msdeb_top_tb
